// ===== stp_consts.svh
// constants of the speech test port: encodings, widths and clock rates
`ifndef STP_CONSTS_SVH
`define STP_CONSTS_SVH
`define STP_CORE_HZ 125000000
`define STP_BIT_HZ 104000
`define STP_SAMPLE_HZ 8000
`define STP_WORD_BITS 13
`define STP_LAST_BIT 4'hC
`define STP_ACC_STEP (2 * `STP_BIT_HZ)
`define STP_MODE_NORMAL 2'h0
`define STP_MODE_DL 2'h1
`define STP_MODE_UL 2'h2
`define STP_MODE_AC 2'h3
`define STP_ST_IDLE 2'h0
`define STP_ST_HOLD 2'h1
`define STP_ST_RUN 2'h3
`endif

// ===== stp_pkg.sv
// types of the speech test port
`include "stp_consts.svh"
package stp_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = `STP_ST_IDLE,
    ST_HOLD = `STP_ST_HOLD,
    ST_RUN = `STP_ST_RUN
  } stp_state_t;

  typedef enum logic [1:0] {
    MODE_NORMAL = `STP_MODE_NORMAL,
    MODE_DL = `STP_MODE_DL,
    MODE_UL = `STP_MODE_UL,
    MODE_AC = `STP_MODE_AC
  } stp_mode_t;

  typedef struct packed {
    logic [27:0] acc;
    logic tick;
  } stp_gen_t;

  typedef struct packed {
    logic [3:0][2:0] sync;
    logic [3:0] clean;
    stp_state_t state;
    stp_mode_t mode_reg;
    stp_mode_t mode_out;
    logic busy;
    logic sclk;
    logic dout;
    logic [3:0] bit_cnt;
    logic [12:0] shift_out;
    logic [12:0] shift_in;
    logic [12:0] ul_sample;
    logic ul_valid;
    logic [12:0] dl_hold;
    logic dl_pend;
    logic xcdr_rst;
  } stp_core_t;
endpackage : stp_pkg

// ===== stp_tick_if.sv
// half-bit tick link between the port core and its rate generator
`timescale 1ns/1ps
interface stp_tick_if;
  logic en;
  logic half_tick;
  modport gen (input en, output half_tick);
  modport use_side (output en, input half_tick);
endinterface : stp_tick_if

// ===== stp_clkgen.sv
// fractional rate generator giving half-bit ticks of the port clock
`timescale 1ns/1ps
`include "stp_consts.svh"
module stp_clkgen (
  input wire logic core_clk_i,
  input wire logic rst_i,
  stp_tick_if.gen tick
);
  stp_pkg::stp_gen_t gen_reg;
  stp_pkg::stp_gen_t gen_next;
  logic [27:0] sum;

  // accumulator keeps the average rate exact; jitter is one core cycle
  always_comb begin
    gen_next = gen_reg;
    sum = gen_reg.acc + 28'(`STP_ACC_STEP);
    gen_next.tick = 1'b0;
    if (!tick.en) begin
      gen_next.acc = 28'h0000000;
    end else if (sum >= 28'(`STP_CORE_HZ)) begin
      gen_next.acc = sum - 28'(`STP_CORE_HZ);
      gen_next.tick = 1'b1;
    end else begin
      gen_next.acc = sum;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      gen_reg <= '0;
    end else begin
      gen_reg <= gen_next;
    end
  end

  assign tick.half_tick = gen_reg.tick;
endmodule : stp_clkgen

// ===== stp_port.sv
// handset side of the speech test port: clock, shifting and mode decode
// What this block does
// - samples are 13-bit linear words, 8000/s
// - one serial line per direction, 104 kbit/s
// - tester reset line resets the transcoder
// - handset clocks only when bits are needed
// - clock runs at 104 kHz within 20 ppm
// - inject on the uplink path, extract on the downlink path
// - bypass commanded by control lines here
// - reset line asserted low, released high
// - two's complement words, MSB first
// - sample on rise, change on fall, idle high
// - control line pair decodes to four modes
`timescale 1ns/1ps
`include "stp_consts.svh"
module stp_port (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic tst_rst_n_i,
  input wire logic ctrl1_i,
  input wire logic ctrl2_i,
  input wire logic data_i,
  output logic sclk_o,
  output logic data_o,
  input wire logic [12:0] dl_sample_i,
  input wire logic dl_valid_i,
  output logic [12:0] ul_sample_o,
  output logic ul_valid_o,
  output logic [1:0] mode_o,
  output logic xcdr_rst_o
);
  stp_pkg::stp_core_t r;
  stp_pkg::stp_core_t n;
  logic [3:0] pins;
  stp_pkg::stp_mode_t mode_now;
  logic [12:0] word;

  stp_tick_if tick ();

  stp_clkgen u_gen (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .tick(tick.gen)
  );

  function automatic logic takes_in(input stp_pkg::stp_mode_t m);
    takes_in = (m == stp_pkg::MODE_UL) || (m == stp_pkg::MODE_AC);
  endfunction : takes_in

  function automatic logic sends_out(input stp_pkg::stp_mode_t m);
    sends_out = (m == stp_pkg::MODE_DL) || (m == stp_pkg::MODE_AC);
  endfunction : sends_out

  assign pins = {data_i, ctrl2_i, ctrl1_i, tst_rst_n_i};

  always_comb begin
    n = r;
    word = 13'h0000;
    n.ul_valid = 1'b0;
    // a pin level counts once second and third stage agree
    for (int i = 0; i < 4; i++) begin
      n.sync[i] = {r.sync[i][1:0], pins[i]};
      if (r.sync[i][2] == r.sync[i][1]) begin
        n.clean[i] = r.sync[i][2];
      end
    end
    mode_now = stp_pkg::stp_mode_t'({r.clean[1], r.clean[2]});
    n.mode_out = mode_now;
    n.xcdr_rst = ~r.clean[0];
    case (r.state)
      stp_pkg::ST_IDLE: begin
        n.sclk = 1'b1;
        n.busy = 1'b0;
        if (!r.clean[0]) begin
          n.state = stp_pkg::ST_HOLD;
        end
      end
      stp_pkg::ST_HOLD: begin
        n.sclk = 1'b1;
        n.busy = 1'b0;
        n.bit_cnt = 4'h0;
        if (r.clean[0]) begin
          if (mode_now != stp_pkg::MODE_NORMAL) begin
            n.state = stp_pkg::ST_RUN;
            n.mode_reg = mode_now;
          end else begin
            n.state = stp_pkg::ST_IDLE;
          end
        end
      end
      stp_pkg::ST_RUN: begin
        // a mode change needs a fresh reset pulse to restart the test
        if (mode_now != r.mode_reg || !r.clean[0]) begin
          n.state = r.clean[0] ? stp_pkg::ST_IDLE : stp_pkg::ST_HOLD;
          n.sclk = 1'b1;
          n.busy = 1'b0;
          n.bit_cnt = 4'h0;
        end else if (!r.busy) begin
          if (takes_in(r.mode_reg) || r.dl_pend) begin
            n.busy = 1'b1;
          end
        end else if (tick.half_tick) begin
          if (r.sclk) begin
            n.sclk = 1'b0;
            if (r.bit_cnt == 4'h0) begin
              if (sends_out(r.mode_reg) && r.dl_pend) begin
                word = r.dl_hold;
                n.dl_pend = 1'b0;
              end
              n.dout = word[12];
              n.shift_out = {word[11:0], 1'b0};
            end else begin
              n.dout = r.shift_out[12];
              n.shift_out = {r.shift_out[11:0], 1'b0};
            end
          end else begin
            n.sclk = 1'b1;
            n.shift_in = {r.shift_in[11:0], r.clean[3]};
            if (r.bit_cnt == `STP_LAST_BIT) begin
              n.bit_cnt = 4'h0;
              if (takes_in(r.mode_reg)) begin
                n.ul_sample = {r.shift_in[11:0], r.clean[3]};
                n.ul_valid = 1'b1;
              end else if (!r.dl_pend) begin
                n.busy = 1'b0;
              end
            end else begin
              n.bit_cnt = r.bit_cnt + 4'h1;
            end
          end
        end
      end
      default: begin
        n.state = stp_pkg::ST_IDLE;
        n.sclk = 1'b1;
        n.busy = 1'b0;
      end
    endcase
    // set wins: a sample arriving during a load stays pending
    if (dl_valid_i) begin
      n.dl_hold = dl_sample_i;
      n.dl_pend = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.sclk <= 1'b1;
      r.dout <= 1'b1;
      r.xcdr_rst <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // rate generator runs only while clocking
  assign tick.en = r.busy && (r.state == stp_pkg::ST_RUN);

  assign sclk_o = r.sclk;
  assign data_o = r.dout;
  assign ul_sample_o = r.ul_sample;
  assign ul_valid_o = r.ul_valid;
  assign mode_o = r.mode_out;
  assign xcdr_rst_o = r.xcdr_rst;

  localparam int HALF_LO = `STP_CORE_HZ / (2 * `STP_BIT_HZ);
  localparam int HALF_HI = HALF_LO + 1;
  logic [11:0] hc;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      hc <= 12'h000;
    end else if (sclk_o != $past(sclk_o)) begin
      hc <= 12'h001;
    end else if (hc != 12'hFFF) begin
      hc <= hc + 12'h001;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  bit_count_a: assert property (
    r.bit_cnt <= `STP_LAST_BIT
  ) else $error("bit counter past word end");

  half_period_a: assert property (
    ($rose(sclk_o) && r.state == stp_pkg::ST_RUN)
      |-> (hc >= HALF_LO && hc <= HALF_HI)
  ) else $error("clock low phase off rate");

  idle_high_a: assert property (
    (r.state != stp_pkg::ST_RUN) |-> sclk_o
  ) else $error("clock not high outside a test");

  fall_change_a: assert property (
    (r.state == stp_pkg::ST_RUN && $changed(data_o)) |-> $fell(sclk_o)
  ) else $error("data changed off the falling edge");

  word_done_a: assert property (
    ul_valid_o |-> ($rose(sclk_o) ##1 !ul_valid_o)
  ) else $error("sample strobe off the rising edge");

  xcdr_reset_a: assert property (
    (!r.clean[0] ##1 !r.clean[0]) |-> xcdr_rst_o
  ) else $error("transcoder reset not following line");

  normal_quiet_a: assert property (
    (mode_o == stp_pkg::MODE_NORMAL) |=> ##1 sclk_o[*3]
  ) else $error("clock running in normal mode");

  mode_decode_a: assert property (
    ({r.clean[1], r.clean[2]} == 2'h2) |=> (mode_o == stp_pkg::MODE_UL)
  ) else $error("control lines decoded wrongly");

  msb_first_a: assert property (
    ($fell(sclk_o) && $past(r.bit_cnt) == 4'h0 && $past(r.dl_pend)
      && $past(r.mode_reg) == stp_pkg::MODE_DL)
      |-> (data_o == $past(r.dl_hold[12]))
  ) else $error("first bit is not the sign bit");

  ul_word_c: cover property (ul_valid_o && r.mode_reg == stp_pkg::MODE_UL);
  dl_word_c: cover property (
    $fell(sclk_o) && r.mode_reg == stp_pkg::MODE_DL);
  ac_both_c: cover property (ul_valid_o && r.mode_reg == stp_pkg::MODE_AC);
  start_c: cover property (
    r.state == stp_pkg::ST_HOLD ##1 r.state == stp_pkg::ST_RUN);
endmodule : stp_port

// ===== stp_tester.sv
// tester model: drives the incoming line, captures the outgoing line
`timescale 1ns/1ps
module stp_tester (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic sclk_i,
  input wire logic rx_i,
  input wire logic [12:0] tx_word_i,
  output logic tx_o,
  output logic [12:0] rx_word_o,
  output logic [7:0] rx_n_o
);
  logic sclk_d = 1'b1;
  logic [3:0] fall_n = 4'h0;
  logic [3:0] rise_n = 4'h0;
  logic [12:0] sh = 13'h0000;
  initial tx_o = 1'b1;
  initial rx_word_o = 13'h0000;
  initial rx_n_o = 8'h00;
  always @(posedge core_clk_i) begin
    sclk_d <= sclk_i;
    if (!rst_n_i) begin
      fall_n <= 4'h0;
      rise_n <= 4'h0;
    end else if (sclk_d && !sclk_i) begin
      tx_o <= tx_word_i[4'hC - fall_n];
      fall_n <= (fall_n == 4'hC) ? 4'h0 : fall_n + 4'h1;
    end else if (!sclk_d && sclk_i) begin
      sh <= {sh[11:0], rx_i};
      rise_n <= (rise_n == 4'hC) ? 4'h0 : rise_n + 4'h1;
      if (rise_n == 4'hC) begin
        rx_word_o <= {sh[11:0], rx_i};
        rx_n_o <= rx_n_o + 8'h01;
      end
    end
  end
endmodule : stp_tester

// ===== speech_test_serial_port_bench.sv
// self-checking bench of the speech test port
`timescale 1ns/1ps
module speech_test_serial_port_bench;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic tst_rst_n_i = 1'b1;
  logic ctrl1_i = 1'b0;
  logic ctrl2_i = 1'b0;
  logic dl_valid_i = 1'b0;
  logic [12:0] dl_sample_i = 13'h0000;
  logic [12:0] tx_word = 13'h0000;
  logic data_i, sclk_o, data_o, ul_valid_o, xcdr_rst_o;
  logic [12:0] ul_sample_o, rx_word;
  logic [1:0] mode_o;
  logic [7:0] rx_n;
  int mismatches = 0;
  int comparisons = 0;

  always #4 core_clk_i = ~core_clk_i;

  stp_port u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .tst_rst_n_i(tst_rst_n_i), .ctrl1_i(ctrl1_i), .ctrl2_i(ctrl2_i),
    .data_i(data_i), .sclk_o(sclk_o), .data_o(data_o),
    .dl_sample_i(dl_sample_i), .dl_valid_i(dl_valid_i),
    .ul_sample_o(ul_sample_o), .ul_valid_o(ul_valid_o),
    .mode_o(mode_o), .xcdr_rst_o(xcdr_rst_o));
  stp_tester u_tester (.core_clk_i(core_clk_i), .rst_n_i(tst_rst_n_i),
    .sclk_i(sclk_o), .rx_i(data_o), .tx_word_i(tx_word), .tx_o(data_i),
    .rx_word_o(rx_word), .rx_n_o(rx_n));

  task chk(input string name, input logic [12:0] exp, input logic [12:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task final_report;
    if (mismatches == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  task cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : cyc

  // mode lines first, then a reset pulse; polls settle by the falling edge
  task set_mode(input logic c1, input logic c2);
    cyc(1);
    ctrl1_i <= c1;
    ctrl2_i <= c2;
    cyc(8);
    tst_rst_n_i <= 1'b0;
    cyc(8);
    @(negedge core_clk_i);
    chk("xcdr_rst_low", 13'h0001, {12'h000, xcdr_rst_o});
    cyc(1);
    tst_rst_n_i <= 1'b1;
    cyc(8);
    @(negedge core_clk_i);
    chk("xcdr_rst_high", 13'h0000, {12'h000, xcdr_rst_o});
    chk("mode", {11'h000, c1, c2}, {11'h000, mode_o});
  endtask : set_mode

  task wait_ul(output int t);
    t = 0;
    @(negedge core_clk_i);
    while (ul_valid_o !== 1'b1 && t < 20000) begin
      @(negedge core_clk_i);
      t++;
    end
    if (t >= 20000) chk("ul_valid_seen", 13'h0001, 13'h0000);
  endtask : wait_ul

  // sclk must stay high: no bits wanted
  task quiet(input int n);
    int lows;
    lows = 0;
    repeat (n) begin
      @(negedge core_clk_i);
      if (sclk_o !== 1'b1) lows++;
    end
    chk("sclk_low_count", 13'h0000, 13'(lows));
  endtask : quiet

  task t_reset;
    @(negedge core_clk_i);
    chk("reset_outs", 13'h0038, {7'h00, sclk_o, data_o, xcdr_rst_o,
      ul_valid_o, mode_o});
  endtask : t_reset

  task t_uplink;
    int t;
    logic ok;
    tx_word <= 13'h1A5B;
    set_mode(1'b1, 1'b0);
    wait_ul(t);
    chk("ul_word1", 13'h1A5B, ul_sample_o);
    tx_word <= 13'h0E1C;
    wait_ul(t);
    chk("ul_word2", 13'h0E1C, ul_sample_o);
    // one word per 15625 core cycles, nco jitter of one cycle
    ok = (t >= 15624 && t <= 15626);
    chk("word_period_ok", 13'h0001, {12'h000, ok});
    cyc(3);
    chk("ul_zero_out", 13'h0000, rx_word);
  endtask : t_uplink

  task t_downlink(input logic c1, input logic [12:0] smp);
    logic [7:0] n0;
    int t;
    set_mode(c1, 1'b1);
    // count words only from the fresh frame after the reset pulse
    n0 = rx_n;
    cyc(1);
    dl_sample_i <= smp;
    dl_valid_i <= 1'b1;
    cyc(1);
    dl_valid_i <= 1'b0;
    t = 0;
    while (rx_n == n0 && t < 20000) begin
      @(negedge core_clk_i);
      t++;
    end
    chk("dl_word", smp, rx_word);
  endtask : t_downlink

  initial begin
    cyc(4);
    rst_i <= 1'b0;
    t_reset();
    set_mode(1'b0, 1'b0);
    quiet(3000);
    t_uplink();
    t_downlink(1'b0, 13'h1C3A);
    quiet(3000);
    tx_word <= 13'h0777;
    t_downlink(1'b1, 13'h1001);
    chk("ac_ul_word", 13'h0777, ul_sample_o);
    final_report();
  end

  initial begin
    // tests need about 68600 cycles; margin for one lost word
    cyc(90000);
    mismatches++;
    final_report();
  end
endmodule : speech_test_serial_port_bench
